// File: core/dsp_pkg.sv
// dsp_pkg: constants and types shared by both ends of the DAC serial port.
// assumes a 40 MHz system clock on both ends; the link clock comes from the
// host.
package dsp_pkg;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	// async frame: start bit, code bits, stop bit
	localparam int FRAME_BITS = WORD_W + 2;
	localparam int OS_RATE = 16;
	localparam int OS_MID = 7;
	localparam int CNT_W = 8;
	localparam int CLK_HZ = 40_000_000;
	localparam int SPI_SCLK_HZ = 1_000_000;
	localparam int ASYNC_BPS_MAX = 150_000;
	localparam int ASYNC_SCLK_HZ = ASYNC_BPS_MAX * OS_RATE;
	// half periods of the link clock in system clocks; rounded up so the
	// link clock never runs faster than its limit
	localparam int SPI_HALF = (CLK_HZ + 2 * SPI_SCLK_HZ - 1)
		/ (2 * SPI_SCLK_HZ);
	localparam int ASYNC_HALF = (CLK_HZ + 2 * ASYNC_SCLK_HZ - 1)
		/ (2 * ASYNC_SCLK_HZ);
	localparam logic [WORD_W-1:0] CODE_RST = 16'h0000;
	localparam logic START_LVL = 1'b0;
	localparam logic STOP_LVL = 1'b1;

	typedef enum logic [6:0] {
		HS_IDLE = 7'h01,
		HS_SEL = 7'h02,
		HS_SHIFT = 7'h04,
		HS_GAP = 7'h08,
		HS_END = 7'h10,
		HS_HOLD = 7'h20,
		HS_ASY = 7'h40
	} dsp_host_st_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} dsp_rx_st_t;
endpackage : dsp_pkg

// File: core/dsp_link_if.sv
// dsp_link_if: the wires between host and DAC serial input.
// assumes the latch wire has a pull-up: released, it reads high.
`timescale 1ns/1ps
interface dsp_link_if;
	logic sclk;
	logic sdi;
	logic latch_drv;
	logic latch_oe_b;
	logic latch;
	logic latch_weak;
	logic sdo;

	// latch wire: driven by host while oe is low, else pulled high
	assign latch = latch_oe_b ? 1'b1 : latch_drv;
	// the device senses that only the pull-up holds the wire
	assign latch_weak = latch_oe_b;

	modport host (
		output sclk,
		output sdi,
		output latch_drv,
		output latch_oe_b,
		input sdo
	);
	modport dev (
		input sclk,
		input sdi,
		input latch,
		input latch_weak,
		output sdo
	);
endinterface : dsp_link_if

// File: core/dsp_dev.sv
// dsp_dev: serial input of the DAC, three-wire and asynchronous modes.
// assumes the link clock comes from the host; code_o is in clk_i domain.
`timescale 1ns/1ps
module dsp_dev
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	dsp_link_if.dev link,
	output logic [dsp_pkg::WORD_W-1:0] code_o,
	output logic update_o,
	output logic async_mode_o
);
	import dsp_pkg::*;

	typedef struct packed {
		logic rs1;
		logic rs2;
		logic md1;
		logic md2;
		logic d1;
		logic d2;
		dsp_rx_st_t st;
		logic [3:0] os;
		logic [4:0] bitn;
		logic [WORD_W-1:0] sh;
		logic [WORD_W-1:0] rx_word;
		logic tgl;
	} dsp_lnk_t;

	typedef struct packed {
		logic l1;
		logic l2;
		logic l3;
		logic t1;
		logic t2;
		logic t3;
		logic m1;
		logic m2;
		logic [WORD_W-1:0] code;
		logic upd;
	} dsp_sys_t;

	dsp_lnk_t k;
	dsp_lnk_t next_k;
	dsp_sys_t s;
	dsp_sys_t next_s;

	// link-clock domain
	always_comb begin
		next_k = k;
		next_k.rs1 = rst_b_i;
		next_k.rs2 = k.rs1;
		next_k.md1 = link.latch_weak;
		next_k.md2 = k.md1;
		next_k.d1 = link.sdi;
		next_k.d2 = k.d1;
		// a low latch can only be a host select: shift at once, as the
		// link-side reset and mode flops get no edges while sclk idles
		if (!link.latch) begin
			next_k.sh = {k.sh[WORD_W-2:0], link.sdi};
			// a word also parks the frame receiver in a known state
			next_k.st = RX_IDLE;
			next_k.os = 4'h0;
			next_k.bitn = 5'h00;
			next_k.tgl = 1'b0;
		end else if (!k.rs2) begin
			next_k.st = RX_IDLE;
			next_k.os = 4'h0;
			next_k.bitn = 5'h00;
			next_k.sh = CODE_RST;
			next_k.rx_word = CODE_RST;
			next_k.tgl = 1'b0;
		end else if (!k.md2) begin
			next_k.st = RX_IDLE;
		end else begin
			next_k.os = k.os + 4'h1;
			case (k.st)
				RX_IDLE: begin
					next_k.os = 4'h0;
					if (k.d2 == START_LVL) begin
						next_k.st = RX_START;
					end
				end
				RX_START: begin
					if (k.os == 4'(OS_MID)) begin
						next_k.os = 4'h0;
						next_k.bitn = 5'h00;
						next_k.st = (k.d2 == START_LVL) ? RX_DATA : RX_IDLE;
					end
				end
				RX_DATA: begin
					if (k.os == 4'(OS_RATE - 1)) begin
						next_k.sh = {k.sh[WORD_W-2:0], k.d2};
						next_k.bitn = k.bitn + 5'h01;
						if (k.bitn == 5'(WORD_W - 1)) begin
							next_k.st = RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (k.os == 4'(OS_RATE - 1)) begin
						next_k.st = RX_IDLE;
						if (k.d2 == STOP_LVL) begin
							next_k.rx_word = k.sh;
							next_k.tgl = ~k.tgl;
						end
					end
				end
				default: next_k.st = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge link.sclk) begin
		k <= next_k;
	end

	assign link.sdo = k.sh[WORD_W-1];

	// system-clock domain
	always_comb begin
		next_s = s;
		next_s.l1 = link.latch;
		next_s.l2 = s.l1;
		next_s.l3 = s.l2;
		next_s.t1 = k.tgl;
		next_s.t2 = s.t1;
		next_s.t3 = s.t2;
		next_s.m1 = link.latch_weak;
		next_s.m2 = s.m1;
		next_s.upd = 1'b0;
		if (!s.m2 && s.l2 && !s.l3) begin
			next_s.code = k.sh;
			next_s.upd = 1'b1;
		end else if (s.m2 && (s.t2 != s.t3)) begin
			next_s.code = k.rx_word;
			next_s.upd = 1'b1;
		end
		if (!rst_b_i) begin
			next_s.l1 = 1'b1;
			next_s.l2 = 1'b1;
			next_s.l3 = 1'b1;
			next_s.m1 = 1'b0;
			next_s.m2 = 1'b0;
			next_s.t3 = s.t2;
			next_s.code = CODE_RST;
			next_s.upd = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		s <= next_s;
	end

	assign code_o = s.code;
	assign update_o = s.upd;
	assign async_mode_o = s.m2;
endmodule : dsp_dev

// File: core/dsp_host.sv
// dsp_host: host end of the DAC serial port; makes the link clock by a
// divider of clk_i and sends one code word per request.
// assumes the link wires reach the DAC directly or through isolators.
//
// Function
// - pull-up on latch selects async mode
// - async link clock is sixteen bit rate
// - async rate at most 150 kbps
// - data, clock, select go to DAC
// - latch low through whole transfer
// - data valid at rising clock edges
// - upper code byte first, then lower
// - latch high after last bit loads
// - clock idles low, sample first edge
// - strobe pin drives latch input
// - async word framed by start, stop
// - clock idle while latch updates DAC
// - shift register tail chains devices
`timescale 1ns/1ps
module dsp_host
#(
	parameter logic [dsp_pkg::CNT_W-1:0] SPI_HALF_P =
		dsp_pkg::CNT_W'(dsp_pkg::SPI_HALF),
	parameter logic [dsp_pkg::CNT_W-1:0] ASYNC_HALF_P =
		dsp_pkg::CNT_W'(dsp_pkg::ASYNC_HALF)
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic mode_i,
	input wire logic [dsp_pkg::WORD_W-1:0] word_i,
	input wire logic valid_i,
	output logic ready_o,
	output logic done_o,
	dsp_link_if.host link
);
	import dsp_pkg::*;

	typedef struct packed {
		dsp_host_st_t state;
		logic [CNT_W-1:0] hcnt;
		logic mode;
		logic sclk;
		logic sdi;
		logic lat_drv;
		logic lat_oe_b;
		logic [4:0] bitn;
		logic [3:0] osn;
		logic [FRAME_BITS-1:0] sh;
		logic ready;
		logic done;
	} dsp_hst_t;

	dsp_hst_t s;
	dsp_hst_t next_s;
	logic tick;
	logic [CNT_W-1:0] half;

	assign half = s.mode ? ASYNC_HALF_P : SPI_HALF_P;
	assign tick = (s.hcnt == '0);

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		// link clock divider: one tick per half period
		if (tick) begin
			next_s.hcnt = half - CNT_W'(1);
		end else begin
			next_s.hcnt = s.hcnt - CNT_W'(1);
		end
		case (s.state)
			HS_IDLE: begin
				next_s.ready = 1'b1;
				next_s.mode = mode_i;
				next_s.sdi = STOP_LVL;
				next_s.lat_drv = 1'b1;
				next_s.lat_oe_b = mode_i;
				if (s.mode) begin
					if (tick) begin
						next_s.sclk = ~s.sclk;
					end
				end else begin
					next_s.sclk = 1'b0;
				end
				if (valid_i && s.ready) begin
					next_s.ready = 1'b0;
					next_s.bitn = 5'h00;
					next_s.osn = 4'h0;
					if (s.mode) begin
						next_s.sh = {START_LVL, word_i, STOP_LVL};
						next_s.sdi = START_LVL;
						next_s.state = HS_ASY;
					end else begin
						next_s.sh = {word_i, 2'b00};
						next_s.sdi = word_i[WORD_W-1];
						next_s.lat_drv = 1'b0;
						// restart the divider: select leads first edge
						next_s.hcnt = half - CNT_W'(1);
						next_s.state = HS_SEL;
					end
				end
			end
			HS_SEL: begin
				if (tick) begin
					next_s.state = HS_SHIFT;
				end
			end
			HS_SHIFT: begin
				if (tick) begin
					if (!s.sclk) begin
						next_s.sclk = 1'b1;
					end else begin
						next_s.sclk = 1'b0;
						next_s.sh = {s.sh[FRAME_BITS-2:0], 1'b0};
						next_s.sdi = s.sh[FRAME_BITS-2];
						next_s.bitn = s.bitn + 5'h01;
						if (s.bitn == 5'(WORD_W - 1)) begin
							next_s.state = HS_END;
						end else if (s.bitn == 5'(BYTE_W - 1)) begin
							next_s.state = HS_GAP;
						end
					end
				end
			end
			HS_GAP: begin
				// byte boundary, as a byte-wide port would leave
				if (tick) begin
					next_s.state = HS_SHIFT;
				end
			end
			HS_END: begin
				if (tick) begin
					next_s.lat_drv = 1'b1;
					next_s.state = HS_HOLD;
				end
			end
			HS_HOLD: begin
				next_s.sclk = 1'b0;
				if (tick) begin
					next_s.done = 1'b1;
					next_s.state = HS_IDLE;
				end
			end
			HS_ASY: begin
				if (tick) begin
					next_s.sclk = ~s.sclk;
					if (s.sclk) begin
						next_s.osn = s.osn + 4'h1;
						if (s.osn == 4'(OS_RATE - 1)) begin
							if (s.bitn == 5'(FRAME_BITS - 1)) begin
								next_s.sdi = STOP_LVL;
								next_s.done = 1'b1;
								next_s.state = HS_IDLE;
							end else begin
								next_s.bitn = s.bitn + 5'h01;
								next_s.sh = {s.sh[FRAME_BITS-2:0], 1'b0};
								next_s.sdi = s.sh[FRAME_BITS-2];
							end
						end
					end
				end
			end
			default: begin
				next_s.state = HS_IDLE;
			end
		endcase
		if (!rst_b_i) begin
			next_s.state = HS_IDLE;
			next_s.hcnt = '0;
			next_s.mode = 1'b0;
			next_s.sclk = 1'b0;
			next_s.sdi = STOP_LVL;
			next_s.lat_drv = 1'b1;
			next_s.lat_oe_b = 1'b0;
			next_s.bitn = 5'h00;
			next_s.osn = 4'h0;
			next_s.sh = '0;
			next_s.ready = 1'b0;
			next_s.done = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		s <= next_s;
	end

	assign link.sclk = s.sclk;
	assign link.sdi = s.sdi;
	assign link.latch_drv = s.lat_drv;
	assign link.latch_oe_b = s.lat_oe_b;
	assign ready_o = s.ready;
	assign done_o = s.done;
endmodule : dsp_host

// File: dv/dsp_assertions.sv
// dsp_assertions: timing checks on the wires between host and DAC end.
// assumes the link wires are sampled on the 40 MHz system clock.
`timescale 1ns/1ps
module dsp_assertions #(
	parameter int HALF = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic latch,
	input wire logic latch_weak
);
	localparam int T_MIN = 30 * HALF;
	localparam int T_MAX = 40 * HALF;
	logic [5:0] rises;

	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// link clock rises while the select is low
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || latch) begin
			rises <= 6'h00;
		end else if ($rose(sclk)) begin
			rises <= rises + 6'h01;
		end
	end

	sequence s_word;
		##[T_MIN:T_MAX] $rose(latch);
	endsequence

	property p_latch_hold;
		$fell(latch) |-> !latch [*8];
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("select rose early");

	property p_sdi_stable;
		sclk && !latch |-> $stable(sdi);
	endproperty
	a_sdi_stable: assert property (p_sdi_stable)
		else $error("data moved while clock high");

	property p_sclk_half;
		$rose(sclk) |-> ##HALF $fell(sclk);
	endproperty
	a_sclk_half: assert property (p_sclk_half)
		else $error("link clock high time wrong");

	property p_xfer;
		$fell(latch) && !latch_weak |-> s_word;
	endproperty
	a_xfer: assert property (p_xfer)
		else $error("select did not return high");

	property p_bits;
		$rose(latch) && !latch_weak |-> rises == 6'h10;
	endproperty
	a_bits: assert property (p_bits)
		else $error("word not sixteen clock rises");

	property p_rise_idle;
		$rose(latch) && !latch_weak |-> !sclk && !$past(sclk);
	endproperty
	a_rise_idle: assert property (p_rise_idle)
		else $error("clock active at update");

	property p_sclk_idle;
		latch && !latch_weak |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("clock not idle low");

	property p_async_bit;
		latch_weak && $changed(sdi) |=> $stable(sdi) [*8];
	endproperty
	a_async_bit: assert property (p_async_bit)
		else $error("async bit too short");
endmodule : dsp_assertions

// File: dv/test_dac_serial_input_port.sv
// test_dac_serial_input_port: sends code words through the host end and
// checks what the DAC end loads. assumes both ends share one clock.
`timescale 1ns/1ps
module test_dac_serial_input_port;
	import dsp_pkg::*;
	localparam int HALF = 2;
	logic clk_i;
	logic rst_b_i;
	logic mode_i;
	logic [WORD_W-1:0] word_i;
	logic valid_i;
	logic ready_o;
	logic done_o;
	logic [WORD_W-1:0] code_o;
	logic update_o;
	logic async_mode_o;
	logic [WORD_W-1:0] wire_word;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int updates = 0;
	logic [WORD_W-1:0] codes [4] = '{16'hA55A, 16'hFFFF, 16'h0001, 16'h8000};

	dsp_link_if link ();
	dsp_host #(.SPI_HALF_P(8'(HALF)), .ASYNC_HALF_P(8'(HALF))) u_dsp_host (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode_i),
		.word_i(word_i), .valid_i(valid_i), .ready_o(ready_o),
		.done_o(done_o), .link(link));
	dsp_dev u_dsp_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
		.code_o(code_o), .update_o(update_o),
		.async_mode_o(async_mode_o));
	dsp_assertions #(.HALF(HALF)) u_dsp_assertions (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .sclk(link.sclk), .sdi(link.sdi),
		.latch(link.latch), .latch_weak(link.latch_weak));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge link.sclk) begin
		if (link.latch === 1'b0) begin
			wire_word <= {wire_word[WORD_W-2:0], link.sdi};
		end
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (update_o === 1'b1) begin
			updates <= updates + 1;
		end
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one request; a changed word while busy must be ignored
	task automatic send(input logic [WORD_W-1:0] w, input logic asy);
		int n;
		int u;
		n = 0;
		while (ready_o !== 1'b1 && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
		u = updates;
		word_i = w;
		valid_i = 1'b1;
		@(negedge clk_i);
		word_i = ~w;
		repeat (3) @(negedge clk_i);
		valid_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
		repeat (8) @(negedge clk_i);
		check("code", code_o, w);
		check("updates", 16'(updates - u), 16'h0001);
		if (!asy) begin
			check("wire word", wire_word, w);
			check("chain out", 16'(link.sdo), 16'(w[15]));
		end
	endtask : send

	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	initial begin
		rst_b_i = 1'b0;
		mode_i = 1'b0;
		word_i = 16'h0000;
		valid_i = 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_b_i = 1'b1;
		check("code reset", code_o, CODE_RST);
		check("async flag", 16'(async_mode_o), 16'h0000);
		foreach (codes[i]) begin
			send(codes[i], 1'b0);
		end
		$display("three-wire test done");
		mode_i = 1'b1;
		repeat (10) @(negedge clk_i);
		check("async flag", 16'(async_mode_o), 16'h0001);
		check("async idle", 16'(link.sdi), 16'(STOP_LVL));
		send(16'h3C96, 1'b1);
		send(16'hC3A5, 1'b1);
		$display("async test done");
		close_out();
	end
endmodule : test_dac_serial_input_port
